// File: bench/dtc_pin_model.sv
// pin model: count and interrupt lines outside the timer block
`default_nettype none

// ==================================================================
// pins idle high through their pull-ups
module dtc_pin_model (
    input wire logic clk_i,
    output logic [3:0] pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial pin_o = 4'hf;

    // each level held 16 clocks, over one machine cycle at code 0
    task automatic pulses(input int idx, input int n);
        repeat (n) begin
            repeat (16) @(posedge clk_i);
            pin_o[idx] <= 1'b0;
            repeat (16) @(posedge clk_i);
            pin_o[idx] <= 1'b1;
        end
    endtask : pulses

    // requester raises and removes its own request
    task automatic hold(input int idx, input logic lvl);
        @(posedge clk_i);
        pin_o[idx] <= lvl;
    endtask : hold
endmodule : dtc_pin_model

`default_nettype wire

// File: bench/dtc_top_chk.sv
// checker: port timing of the dual timer block
`default_nettype none

// ==================================================================
// assertions
module dtc_top_chk (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire dtc_pkg::dtc_sfr_req_s sfr_req_i,
    input wire logic [2:0] core_clock_divider_code_i,
    input wire logic [3:0] vector_ack_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [3:0] irq_request_o,
    input wire logic machine_cycle_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic mc;
    logic c0;
    logic [7:0] ad;
    logic [7:0] r;
    assign mc = machine_cycle_o;
    assign c0 = core_clock_divider_code_i == 3'h0;
    assign ad = sfr_req_i.addr;
    assign r = sfr_rdata_o;

    AST_MC_PULSE: assert property (mc |=> !mc [*8])
        else $error("machine cycle pulses too close");
    AST_MC_PERIOD: assert property (
        mc && c0 ##1 c0 [*8] ##1 c0 [*3] |=> mc)
        else $error("machine cycle not twelve clocks");
    AST_UNMAPPED: assert property (
        !(ad inside {[8'h88:8'h8d]}) |=> r == 8'h00)
        else $error("unmapped read not zero");
    AST_READBACK: assert property (
        sfr_req_i.wr && ad == dtc_pkg::ADDR_A_LOW
        ##1 ad == dtc_pkg::ADDR_A_LOW
        |=> r == $past(sfr_req_i.wdata, 2))
        else $error("written count byte lost");
    AST_MIRROR: assert property (
        ad == dtc_pkg::ADDR_CTRL |=> {r[7], r[3], r[5], r[1]} == irq_request_o)
        else $error("requests differ from flags");
    AST_ACK_A: assert property (
        vector_ack_i[1] && !mc ##1 !mc ##1 !mc |-> !irq_request_o[1])
        else $error("ack left timer a flag set");
    AST_ACK_B: assert property (
        (!mc throughout (vector_ack_i[3] ##2 1'b1)) |-> !irq_request_o[3])
        else $error("ack left timer b flag set");
    AST_OVF_AT_UPDATE: assert property (
        $rose(irq_request_o[1]) |-> mc || $past(mc) || $past(sfr_req_i.wr, 2))
        else $error("timer a flag set off update");
endmodule : dtc_top_chk

`default_nettype wire

// File: bench/tb.sv
// testbench: registers, modes and pins of the dual timer block
`default_nettype none

// ==================================================================
// bench top
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [2:0] c; int p;} dtc_row_s;
    dtc_row_s rows[4] = '{'{3'h0, 12}, '{3'h1, 24}, '{3'h3, 96},
        '{3'h7, 1536}};
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    dtc_pkg::dtc_sfr_req_s req = '0;
    logic [2:0] code = 3'h0;
    logic [3:0] ack = 4'h0;
    logic [3:0] pin;
    logic [7:0] rdata;
    logic [3:0] irq;
    logic [3:0] irq_seen;
    logic mc;
    int n;
    int n_fail = 0;
    int compares = 0;

    always #12.5 clk_i = ~clk_i;

    dtc_top i_dtc_top (.clk_i, .reset_i, .sfr_req_i(req),
        .core_clock_divider_code_i(code), .ext_irq_a_pin_i(pin[0]),
        .ext_irq_b_pin_i(pin[1]), .timer_a_count_pin_i(pin[2]),
        .timer_b_count_pin_i(pin[3]), .vector_ack_i(ack),
        .sfr_rdata_o(rdata), .irq_request_o(irq), .machine_cycle_o(mc));
    dtc_pin_model i_dtc_pin_model (.clk_i, .pin_o(pin));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) req <= '{a, 1'b1, d};
        @(posedge clk_i) req.wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i) req <= '{a, 1'b0, 8'h00};
        @(posedge clk_i) #1 check(rdata, exp);
    endtask : rdc

    task automatic set_a(input logic [7:0] m, input logic [7:0] lo,
                         input logic [7:0] hi);
        wr(dtc_pkg::ADDR_MODE, m);
        wr(dtc_pkg::ADDR_A_LOW, lo);
        wr(dtc_pkg::ADDR_A_HIGH, hi);
    endtask : set_a

    task automatic wait_mc;
        do @(posedge clk_i); while (mc !== 1'b1);
    endtask : wait_mc

    // run for k update points, note the requests, ack all, stop
    task automatic steps(input logic [7:0] run, input int k);
        wait_mc;
        wr(dtc_pkg::ADDR_CTRL, run);
        repeat (k) wait_mc;
        @(posedge clk_i) #1 irq_seen = irq;
        @(posedge clk_i) ack <= 4'hf;
        @(posedge clk_i) ack <= 4'h0;
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
    endtask : steps

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    initial begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        rdc(dtc_pkg::ADDR_CTRL, 8'h00);
        rdc(dtc_pkg::ADDR_MODE, 8'h00);
        wr(8'h8e, 8'hff);
        rdc(8'h8e, 8'h00);
        done("reset");
        foreach (rows[i]) begin
            @(posedge clk_i) code <= rows[i].c;
            wait_mc;
            wait_mc;
            n = 0;
            do begin @(posedge clk_i); n++; end while (mc !== 1'b1);
            check(n, rows[i].p);
        end
        @(posedge clk_i) code <= 3'h0;
        done("divider");
        set_a(8'h00, 8'hff, 8'h05);
        steps(8'h10, 1);
        rdc(dtc_pkg::ADDR_A_LOW, 8'he0);
        rdc(dtc_pkg::ADDR_A_HIGH, 8'h06);
        set_a(8'h01, 8'hfe, 8'hff);
        steps(8'h10, 2);
        check(irq_seen[1], 1'b1);
        rdc(dtc_pkg::ADDR_A_LOW, 8'h00);
        rdc(dtc_pkg::ADDR_A_HIGH, 8'h00);
        set_a(8'h02, 8'hfe, 8'h80);
        steps(8'h10, 3);
        check(irq_seen[1], 1'b1);
        rdc(dtc_pkg::ADDR_A_LOW, 8'h81);
        rdc(dtc_pkg::ADDR_A_HIGH, 8'h80);
        set_a(8'h03, 8'h10, 8'hff);
        steps(8'h50, 1);
        rdc(dtc_pkg::ADDR_A_LOW, 8'h11);
        rdc(dtc_pkg::ADDR_A_HIGH, 8'h00);
        check(irq_seen[3], 1'b1);
        wr(dtc_pkg::ADDR_MODE, 8'h30);
        wr(dtc_pkg::ADDR_B_LOW, 8'h42);
        steps(8'h40, 2);
        rdc(dtc_pkg::ADDR_B_LOW, 8'h42);
        done("modes");
        i_dtc_pin_model.hold(0, 1'b0);
        set_a(8'h09, 8'h00, 8'h00);
        steps(8'h10, 2);
        rdc(dtc_pkg::ADDR_A_LOW, 8'h00);
        check(irq_seen[0], 1'b1);
        i_dtc_pin_model.hold(0, 1'b1);
        steps(8'h10, 2);
        rdc(dtc_pkg::ADDR_A_LOW, 8'h02);
        check(irq_seen[0], 1'b0);
        set_a(8'h05, 8'h00, 8'h00);
        wr(dtc_pkg::ADDR_CTRL, 8'h10);
        i_dtc_pin_model.pulses(2, 3);
        repeat (40) @(posedge clk_i);
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
        rdc(dtc_pkg::ADDR_A_LOW, 8'h03);
        done("gate and counter");
        wr(dtc_pkg::ADDR_CTRL, 8'h04);
        i_dtc_pin_model.hold(1, 1'b0);
        repeat (12) @(posedge clk_i);
        #1 check(irq[2], 1'b1);
        @(posedge clk_i) ack <= 4'h4;
        @(posedge clk_i) ack <= 4'h0;
        repeat (3) @(posedge clk_i);
        #1 check(irq[2], 1'b0);
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
        repeat (12) @(posedge clk_i);
        #1 check(irq[2], 1'b1);
        i_dtc_pin_model.hold(1, 1'b1);
        repeat (12) @(posedge clk_i);
        #1 check(irq[2], 1'b0);
        done("external requests");
        finish_test;
    end

    initial begin
        #(30000 * 25);
        n_fail++;
        finish_test;
    end
endmodule : tb

bind dtc_top dtc_top_chk i_dtc_top_chk (.clk_i, .reset_i, .sfr_req_i,
    .core_clock_divider_code_i, .vector_ack_i, .sfr_rdata_o,
    .irq_request_o, .machine_cycle_o);

`default_nettype wire

// File: hw/dtc_pkg.sv
// package: register map, field layout, timing and carrier types
`default_nettype none

package dtc_pkg;

    // ==================================================================
    // register addresses
    localparam logic [7:0] ADDR_CTRL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_A_LOW = 8'h8a;
    localparam logic [7:0] ADDR_B_LOW = 8'h8b;
    localparam logic [7:0] ADDR_A_HIGH = 8'h8c;
    localparam logic [7:0] ADDR_B_HIGH = 8'h8d;

    // ==================================================================
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] RDATA_NONE = 8'h00;

    // ==================================================================
    // control register bit positions
    localparam int CTRL_B_OVF = 7;
    localparam int CTRL_B_RUN = 6;
    localparam int CTRL_A_OVF = 5;
    localparam int CTRL_A_RUN = 4;
    localparam int CTRL_IRQ_B_FLAG = 3;
    localparam int CTRL_IRQ_B_TRIG = 2;
    localparam int CTRL_IRQ_A_FLAG = 1;
    localparam int CTRL_IRQ_A_TRIG = 0;

    // mode register: timer b in the upper half, timer a in the lower
    localparam int MODE_B_MSB = 7;
    localparam int MODE_B_LSB = 4;
    localparam int MODE_A_MSB = 3;
    localparam int MODE_A_LSB = 0;

    // vector acknowledge and request bit order
    localparam int ACK_IRQ_A = 0;
    localparam int ACK_TMR_A = 1;
    localparam int ACK_IRQ_B = 2;
    localparam int ACK_TMR_B = 3;

    // ==================================================================
    // timing
    localparam int CORE_PER_MC = 12;
    localparam int PHASE_W = 4;
    localparam logic [3:0] PHASE_LAST = 4'hb;
    localparam logic [3:0] PHASE_UPDATE = 4'h4;
    localparam logic [3:0] PHASE_SAMPLE = 4'h9;
    localparam int DIV_W = 7;
    localparam logic [2:0] DIV_CODE_DEFAULT = 3'h3;
    localparam logic [2:0] DIV_CODE_MAX = 3'h7;
    localparam logic [6:0] DIV_MASK_FULL = 7'h7f;

    // ==================================================================
    // types
    typedef enum logic [1:0] {
        MODE_PRESCALED,
        MODE_CASCADED,
        MODE_RELOAD,
        MODE_SPLIT
    } dtc_mode_e;

    typedef struct packed {
        logic gate;
        logic count_ext;
        logic [1:0] mode;
    } dtc_timer_mode_select_half_s;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } dtc_sfr_req_s;

    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic ovf;
    } dtc_step_s;

endpackage : dtc_pkg

`default_nettype wire

// File: hw/dtc_pkg_dummy_never.sv
// empty file: this unit holds no logic
`default_nettype none
`default_nettype wire

// File: hw/dtc_sync.sv
// three-flop pin synchroniser with agreement filter
`default_nettype none

module dtc_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic pin_i,
    output logic level_o
);

    logic stage1;
    logic stage2;
    logic stage3;

    // ==================================================================
    // chain
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
        end else begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // ==================================================================
    // accept a change only when second and third agree
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            level_o <= RESET_VAL;
        end else if (stage2 == stage3) begin
            level_o <= stage3;
        end
    end

endmodule : dtc_sync

`default_nettype wire

// File: hw/dtc_top.sv
// dual timer/counter with external interrupt flags
// Functional notes
// RULE_01: timer mode counts every twelve core clocks
// RULE_02: counter mode counts sampled high-then-low pairs
// RULE_03: counted edge shows in next machine cycle
// RULE_04: source holds each level one machine cycle
// RULE_05: gate bit adds pin-high condition to run
// RULE_06: select bit picks pin or machine cycles
// RULE_07: mode 00 uses five-bit prescale low byte
// RULE_08: mode 01 cascades bytes to sixteen bits
// RULE_09: mode 10 reloads low from high
// RULE_10: mode 11 stops b, splits a
// RULE_11: overflow sets flag, vectoring clears it
// RULE_12: software run bit turns timer on, off
// RULE_13: pin flag by edge or level; ack edge-only
// RULE_14: level mode flag follows the pin
// RULE_15: trigger bit set means falling edge detect
// RULE_16: byte registers act alone or as pair
// RULE_17: divider code halves core clock per step
// RULE_18: mode 00 count is thirteen bits
// RULE_19: run bit keeps count; reload keeps high
// RULE_20: split mode high byte uses b controls
// RULE_21: software count write beats hardware update
`default_nettype none

module dtc_top (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire dtc_pkg::dtc_sfr_req_s sfr_req_i,
    input wire logic [2:0] core_clock_divider_code_i,
    input wire logic ext_irq_a_pin_i,
    input wire logic ext_irq_b_pin_i,
    input wire logic timer_a_count_pin_i,
    input wire logic timer_b_count_pin_i,
    input wire logic [3:0] vector_ack_i,
    output logic [7:0] sfr_rdata_o,
    output logic [3:0] irq_request_o,
    output logic machine_cycle_o
);

    // ==================================================================
    // declarations
    logic [3:0] pins_raw;
    logic [3:0] pins_sync;
    logic irq_a_pin;
    logic irq_b_pin;
    logic [1:0] count_pins;
    logic [dtc_pkg::DIV_W-1:0] div_cnt;
    logic [dtc_pkg::DIV_W-1:0] div_mask;
    logic core_tick;
    logic [dtc_pkg::PHASE_W-1:0] phase;
    logic mc_update;
    logic mc_sample;
    logic [1:0] count_prev;
    logic [1:0] fall_pend;
    logic [1:0] irq_prev;
    logic [7:0] timer_mode_select;
    logic [7:0] timer_a_low_byte;
    logic [7:0] timer_a_high_byte;
    logic [7:0] timer_b_low_byte;
    logic [7:0] timer_b_high_byte;
    logic timer_a_overflow_flag;
    logic timer_b_overflow_flag;
    logic timer_a_run_bit;
    logic timer_b_run_bit;
    logic ext_irq_a_flag;
    logic ext_irq_b_flag;
    logic ext_irq_a_trigger_type;
    logic ext_irq_b_trigger_type;
    dtc_pkg::dtc_timer_mode_select_half_s cfg_a;
    dtc_pkg::dtc_timer_mode_select_half_s cfg_b;
    dtc_pkg::dtc_mode_e mode_a;
    dtc_pkg::dtc_mode_e mode_b;
    logic tick_a;
    logic tick_b;
    logic tick_a_high;
    dtc_pkg::dtc_step_s step_a;
    dtc_pkg::dtc_step_s step_b;
    logic [7:0] next_a_high;
    logic split_high_ovf;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_a_low;
    logic wr_a_high;
    logic wr_b_low;
    logic wr_b_high;
    logic [7:0] ctrl_view;
    logic [7:0] next_rdata;
    logic set_a_ovf;
    logic set_b_ovf;
    logic fall_irq_a;
    logic fall_irq_b;

    // ==================================================================
    // one count step for modes 00 to 10, and the low byte of mode 11
    function automatic dtc_pkg::dtc_step_s timer_step(
        input dtc_pkg::dtc_mode_e mode,
        input logic [7:0] low,
        input logic [7:0] high,
        input logic tick
    );
        dtc_pkg::dtc_step_s r;
        logic [15:0] sum;
        r.low = low;
        r.high = high;
        r.ovf = 1'b0;
        sum = {high, low} + 16'h0001;
        if (tick) begin
            case (mode)
                dtc_pkg::MODE_PRESCALED: begin
                    r.low[4:0] = low[4:0] + 5'h01; // [RULE_07] [RULE_18]
                    if (low[4:0] == 5'h1f) begin
                        r.high = high + 8'h01;
                        r.ovf = (high == 8'hff);
                    end
                end
                dtc_pkg::MODE_CASCADED: begin
                    r.low = sum[7:0]; // [RULE_08] [RULE_16]
                    r.high = sum[15:8];
                    r.ovf = ({high, low} == 16'hffff);
                end
                dtc_pkg::MODE_RELOAD: begin
                    if (low == 8'hff) begin
                        r.low = high; // [RULE_09] [RULE_19]
                        r.ovf = 1'b1;
                    end else begin
                        r.low = low + 8'h01;
                    end
                end
                dtc_pkg::MODE_SPLIT: begin
                    r.low = low + 8'h01; // [RULE_10] [RULE_16]
                    r.ovf = (low == 8'hff);
                end
                default: begin
                    r.low = low;
                end
            endcase
        end
        return r;
    endfunction : timer_step

    // ==================================================================
    // pin synchronisers
    assign pins_raw = {timer_b_count_pin_i, timer_a_count_pin_i,
                       ext_irq_b_pin_i, ext_irq_a_pin_i};

    for (genvar g = 0; g < 4; g++) begin : g_sync
        dtc_sync #(
            .RESET_VAL(1'b1)
        ) u_sync (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .pin_i(pins_raw[g]),
            .level_o(pins_sync[g])
        );
    end

    assign irq_a_pin = pins_sync[0];
    assign irq_b_pin = pins_sync[1];
    assign count_pins = pins_sync[3:2];

    // ==================================================================
    // core clock divider and machine cycle phases
    assign div_mask = dtc_pkg::DIV_MASK_FULL
                      >> (dtc_pkg::DIV_CODE_MAX - core_clock_divider_code_i);
    assign core_tick = ((div_cnt & div_mask) == div_mask); // [RULE_17]

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 7'h01;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase <= '0;
        end else if (core_tick) begin
            if (phase == dtc_pkg::PHASE_LAST) begin // [RULE_01]
                phase <= '0;
            end else begin
                phase <= phase + 4'h1;
            end
        end
    end

    assign mc_update = core_tick && (phase == dtc_pkg::PHASE_UPDATE);
    assign mc_sample = core_tick && (phase == dtc_pkg::PHASE_SAMPLE);

    // ==================================================================
    // count pin sampling, once per machine cycle
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_prev <= 2'h3;
        end else if (mc_sample) begin
            count_prev <= count_pins; // [RULE_02] [RULE_04]
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            fall_pend <= 2'h0;
        end else if (mc_sample) begin
            fall_pend <= fall_pend | (count_prev & ~count_pins); // [RULE_02]
        end else if (mc_update) begin
            fall_pend <= 2'h0; // [RULE_03]
        end
    end

    // ==================================================================
    // count enables
    assign cfg_a = timer_mode_select[dtc_pkg::MODE_A_MSB:dtc_pkg::MODE_A_LSB];
    assign cfg_b = timer_mode_select[dtc_pkg::MODE_B_MSB:dtc_pkg::MODE_B_LSB];
    assign mode_a = dtc_pkg::dtc_mode_e'(cfg_a.mode);
    assign mode_b = dtc_pkg::dtc_mode_e'(cfg_b.mode);

    assign tick_a = mc_update && timer_a_run_bit // [RULE_05] [RULE_12]
                    && (!cfg_a.gate || irq_a_pin)
                    && (!cfg_a.count_ext || fall_pend[0]); // [RULE_06]
    assign tick_b = mc_update && timer_b_run_bit // [RULE_05] [RULE_12]
                    && (!cfg_b.gate || irq_b_pin)
                    && (!cfg_b.count_ext || fall_pend[1]) // [RULE_06]
                    && (mode_b != dtc_pkg::MODE_SPLIT); // [RULE_10]
    assign tick_a_high = mc_update && timer_b_run_bit
                         && (mode_a == dtc_pkg::MODE_SPLIT); // [RULE_20]

    assign step_a = timer_step(mode_a, timer_a_low_byte, timer_a_high_byte,
                               tick_a);
    assign step_b = timer_step(mode_b, timer_b_low_byte, timer_b_high_byte,
                               tick_b);

    always_comb begin
        next_a_high = step_a.high;
        split_high_ovf = 1'b0;
        if (tick_a_high) begin
            next_a_high = timer_a_high_byte + 8'h01; // [RULE_20]
            split_high_ovf = (timer_a_high_byte == 8'hff);
        end
    end

    // ==================================================================
    // register writes
    assign wr_ctrl = sfr_req_i.wr && (sfr_req_i.addr == dtc_pkg::ADDR_CTRL);
    assign wr_mode = sfr_req_i.wr && (sfr_req_i.addr == dtc_pkg::ADDR_MODE);
    assign wr_a_low = sfr_req_i.wr && (sfr_req_i.addr == dtc_pkg::ADDR_A_LOW);
    assign wr_a_high = sfr_req_i.wr
                       && (sfr_req_i.addr == dtc_pkg::ADDR_A_HIGH);
    assign wr_b_low = sfr_req_i.wr && (sfr_req_i.addr == dtc_pkg::ADDR_B_LOW);
    assign wr_b_high = sfr_req_i.wr
                       && (sfr_req_i.addr == dtc_pkg::ADDR_B_HIGH);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_mode_select <= dtc_pkg::MODE_RST;
        end else if (wr_mode) begin
            timer_mode_select <= sfr_req_i.wdata;
        end
    end

    // ==================================================================
    // count registers, software write first
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_a_low_byte <= dtc_pkg::COUNT_RST;
            timer_a_high_byte <= dtc_pkg::COUNT_RST;
        end else begin
            if (wr_a_low) begin
                timer_a_low_byte <= sfr_req_i.wdata; // [RULE_21]
            end else begin
                timer_a_low_byte <= step_a.low; // [RULE_19]
            end
            if (wr_a_high) begin
                timer_a_high_byte <= sfr_req_i.wdata; // [RULE_21]
            end else begin
                timer_a_high_byte <= next_a_high;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_b_low_byte <= dtc_pkg::COUNT_RST;
            timer_b_high_byte <= dtc_pkg::COUNT_RST;
        end else begin
            if (wr_b_low) begin
                timer_b_low_byte <= sfr_req_i.wdata; // [RULE_21]
            end else begin
                timer_b_low_byte <= step_b.low;
            end
            if (wr_b_high) begin
                timer_b_high_byte <= sfr_req_i.wdata; // [RULE_21]
            end else begin
                timer_b_high_byte <= step_b.high;
            end
        end
    end

    // ==================================================================
    // run and trigger bits
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_a_run_bit <= dtc_pkg::CTRL_RST[dtc_pkg::CTRL_A_RUN];
            timer_b_run_bit <= dtc_pkg::CTRL_RST[dtc_pkg::CTRL_B_RUN];
            ext_irq_a_trigger_type <= dtc_pkg::CTRL_RST[dtc_pkg::CTRL_IRQ_A_TRIG];
            ext_irq_b_trigger_type <= dtc_pkg::CTRL_RST[dtc_pkg::CTRL_IRQ_B_TRIG];
        end else if (wr_ctrl) begin
            timer_a_run_bit <= sfr_req_i.wdata[dtc_pkg::CTRL_A_RUN];
            timer_b_run_bit <= sfr_req_i.wdata[dtc_pkg::CTRL_B_RUN];
            ext_irq_a_trigger_type <= sfr_req_i.wdata[dtc_pkg::CTRL_IRQ_A_TRIG];
            ext_irq_b_trigger_type <= sfr_req_i.wdata[dtc_pkg::CTRL_IRQ_B_TRIG];
        end
    end

    // ==================================================================
    // overflow flags, a hardware set beats any clear
    assign set_a_ovf = step_a.ovf; // [RULE_11]
    assign set_b_ovf = (step_b.ovf && (mode_a != dtc_pkg::MODE_SPLIT))
                       || split_high_ovf; // [RULE_20]

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_a_overflow_flag <= dtc_pkg::CTRL_RST[dtc_pkg::CTRL_A_OVF];
        end else if (set_a_ovf) begin
            timer_a_overflow_flag <= 1'b1; // [RULE_11]
        end else if (wr_ctrl) begin
            timer_a_overflow_flag <= sfr_req_i.wdata[dtc_pkg::CTRL_A_OVF];
        end else if (vector_ack_i[dtc_pkg::ACK_TMR_A]) begin
            timer_a_overflow_flag <= 1'b0; // [RULE_11]
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_b_overflow_flag <= dtc_pkg::CTRL_RST[dtc_pkg::CTRL_B_OVF];
        end else if (set_b_ovf) begin
            timer_b_overflow_flag <= 1'b1; // [RULE_11]
        end else if (wr_ctrl) begin
            timer_b_overflow_flag <= sfr_req_i.wdata[dtc_pkg::CTRL_B_OVF];
        end else if (vector_ack_i[dtc_pkg::ACK_TMR_B]) begin
            timer_b_overflow_flag <= 1'b0; // [RULE_11]
        end
    end

    // ==================================================================
    // external interrupt flags
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_prev <= 2'h3;
        end else begin
            irq_prev <= {irq_b_pin, irq_a_pin};
        end
    end

    assign fall_irq_a = irq_prev[0] && !irq_a_pin; // [RULE_15]
    assign fall_irq_b = irq_prev[1] && !irq_b_pin; // [RULE_15]

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ext_irq_a_flag <= dtc_pkg::CTRL_RST[dtc_pkg::CTRL_IRQ_A_FLAG];
        end else if (!ext_irq_a_trigger_type) begin
            ext_irq_a_flag <= !irq_a_pin; // [RULE_14] [RULE_13]
        end else if (fall_irq_a) begin
            ext_irq_a_flag <= 1'b1; // [RULE_13]
        end else if (wr_ctrl) begin
            ext_irq_a_flag <= sfr_req_i.wdata[dtc_pkg::CTRL_IRQ_A_FLAG];
        end else if (vector_ack_i[dtc_pkg::ACK_IRQ_A]) begin
            ext_irq_a_flag <= 1'b0; // [RULE_13]
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ext_irq_b_flag <= dtc_pkg::CTRL_RST[dtc_pkg::CTRL_IRQ_B_FLAG];
        end else if (!ext_irq_b_trigger_type) begin
            ext_irq_b_flag <= !irq_b_pin; // [RULE_14] [RULE_13]
        end else if (fall_irq_b) begin
            ext_irq_b_flag <= 1'b1; // [RULE_13]
        end else if (wr_ctrl) begin
            ext_irq_b_flag <= sfr_req_i.wdata[dtc_pkg::CTRL_IRQ_B_FLAG];
        end else if (vector_ack_i[dtc_pkg::ACK_IRQ_B]) begin
            ext_irq_b_flag <= 1'b0; // [RULE_13]
        end
    end

    // ==================================================================
    // read path and outputs
    assign ctrl_view = {timer_b_overflow_flag, timer_b_run_bit,
                        timer_a_overflow_flag, timer_a_run_bit,
                        ext_irq_b_flag, ext_irq_b_trigger_type,
                        ext_irq_a_flag, ext_irq_a_trigger_type};

    always_comb begin
        case (sfr_req_i.addr)
            dtc_pkg::ADDR_CTRL: next_rdata = ctrl_view;
            dtc_pkg::ADDR_MODE: next_rdata = timer_mode_select;
            dtc_pkg::ADDR_A_LOW: next_rdata = timer_a_low_byte;
            dtc_pkg::ADDR_B_LOW: next_rdata = timer_b_low_byte;
            dtc_pkg::ADDR_A_HIGH: next_rdata = timer_a_high_byte;
            dtc_pkg::ADDR_B_HIGH: next_rdata = timer_b_high_byte;
            default: next_rdata = dtc_pkg::RDATA_NONE;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sfr_rdata_o <= dtc_pkg::RDATA_NONE;
        end else begin
            sfr_rdata_o <= next_rdata;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_request_o <= 4'h0;
            machine_cycle_o <= 1'b0;
        end else begin
            irq_request_o <= {timer_b_overflow_flag, ext_irq_b_flag,
                              timer_a_overflow_flag, ext_irq_a_flag};
            machine_cycle_o <= mc_update;
        end
    end

endmodule : dtc_top

`default_nettype wire
